//--- pkg/ebm_map.svh
`ifndef EBM_MAP_SVH
`define EBM_MAP_SVH

`define EBM_ROWS 256
`define EBM_ROW_BITS 8
`define EBM_WORD_BITS 16
`define EBM_LOC_BITS 11
`define EBM_SYNC_STAGES 2
`define EBM_MASK_W16 16'hffff
`define EBM_MASK_W8 16'h00ff
`define EBM_MASK_W4 16'h000f
`define EBM_MASK_W2 16'h0003
`define EBM_WORD_RESET 16'h0000

`endif

//--- pkg/ebm_pkg.sv
package ebm_pkg;

	typedef enum logic [1:0] {
		EBM_SHAPE_256X16,
		EBM_SHAPE_512X8,
		EBM_SHAPE_1024X4,
		EBM_SHAPE_2048X2
	} ebm_shape_t;

endpackage

//--- rtl/ebm_tile.sv
`timescale 1ns/1ps
`include "ebm_map.svh"

module ebm_tile (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire ebm_pkg::ebm_shape_t shape,
	input wire logic wr_falling,
	input wire logic rd_falling,
	input wire logic wr_clk,
	input wire logic wr_strobe,
	input wire logic wr_clock_gate,
	input wire logic [`EBM_LOC_BITS-1:0] wr_location,
	input wire logic [`EBM_WORD_BITS-1:0] wr_data,
	input wire logic [`EBM_WORD_BITS-1:0] wr_mask,
	input wire logic rd_clk,
	input wire logic rd_strobe,
	input wire logic rd_clock_gate,
	input wire logic [`EBM_LOC_BITS-1:0] rd_location,
	input wire logic init_we,
	input wire logic [`EBM_ROW_BITS-1:0] init_location,
	input wire logic [`EBM_WORD_BITS-1:0] init_word,
	output logic [`EBM_WORD_BITS-1:0] rd_word
);
	import ebm_pkg::*;

	localparam int CTL_W = 3;
	localparam int WRD_W = `EBM_LOC_BITS + 2 * `EBM_WORD_BITS;

	// Bit position of the addressed lane inside a stored row
	function automatic logic [3:0] lane_shift(input ebm_shape_t s,
			input logic [`EBM_LOC_BITS-1:0] loc);
		case (s)
			EBM_SHAPE_512X8: lane_shift = {loc[8], 3'h0};
			EBM_SHAPE_1024X4: lane_shift = {loc[9:8], 2'h0};
			EBM_SHAPE_2048X2: lane_shift = {loc[10:8], 1'h0};
			default: lane_shift = 4'h0;
		endcase
	endfunction

	// Bits of a row owned by the addressed lane
	function automatic logic [15:0] lane_bits(input ebm_shape_t s,
			input logic [`EBM_LOC_BITS-1:0] loc);
		logic [15:0] base;
		base = `EBM_MASK_W16;
		case (s)
			EBM_SHAPE_512X8: base = `EBM_MASK_W8;
			EBM_SHAPE_1024X4: base = `EBM_MASK_W4;
			EBM_SHAPE_2048X2: base = `EBM_MASK_W2;
			default: base = `EBM_MASK_W16;
		endcase
		lane_bits = base << lane_shift(s, loc);
	endfunction

	// Two-flop synchronisers for every pin from the fabric except the init_we preload port, which goes to the array unsynchronised
	logic [CTL_W-1:0] wrc_meta_reg;
	logic [CTL_W-1:0] wrc_sync_reg;
	logic [WRD_W-1:0] wrd_meta_reg;
	logic [WRD_W-1:0] wrd_sync_reg;
	logic [CTL_W-1:0] rdc_meta_reg;
	logic [CTL_W-1:0] rdc_sync_reg;
	logic [`EBM_LOC_BITS-1:0] rdl_meta_reg;
	logic [`EBM_LOC_BITS-1:0] rdl_sync_reg;
	logic [1:0] shape_meta_reg;
	logic [1:0] shape_sync_reg;
	logic [1:0] pol_meta_reg;
	logic [1:0] pol_sync_reg;
	logic wr_clk_prev_reg;
	logic rd_clk_prev_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrc_meta_reg <= '0;
			wrc_sync_reg <= '0;
		end else begin
			wrc_meta_reg <= {wr_clk, wr_strobe, wr_clock_gate};
			wrc_sync_reg <= wrc_meta_reg;
		end
	end

	// Same depth as the controls, so fields stay aligned with the edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrd_meta_reg <= '0;
			wrd_sync_reg <= '0;
		end else begin
			wrd_meta_reg <= {wr_location, wr_data, wr_mask};
			wrd_sync_reg <= wrd_meta_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdc_meta_reg <= '0;
			rdc_sync_reg <= '0;
		end else begin
			rdc_meta_reg <= {rd_clk, rd_strobe, rd_clock_gate};
			rdc_sync_reg <= rdc_meta_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdl_meta_reg <= '0;
			rdl_sync_reg <= '0;
		end else begin
			rdl_meta_reg <= rd_location;
			rdl_sync_reg <= rdl_meta_reg;
		end
	end

	// Shape and polarity are static; synced only to keep them clean
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shape_meta_reg <= '0;
			shape_sync_reg <= '0;
		end else begin
			shape_meta_reg <= shape;
			shape_sync_reg <= shape_meta_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pol_meta_reg <= '0;
			pol_sync_reg <= '0;
		end else begin
			pol_meta_reg <= {wr_falling, rd_falling};
			pol_sync_reg <= pol_meta_reg;
		end
	end

	// Unpacked synchronised fields
	logic s_wr_clk;
	logic s_wr_en;
	logic s_wr_gate;
	logic [`EBM_LOC_BITS-1:0] s_wr_loc;
	logic [`EBM_WORD_BITS-1:0] s_wr_data;
	logic [`EBM_WORD_BITS-1:0] s_wr_mask;
	logic s_rd_clk;
	logic s_rd_en;
	logic s_rd_gate;
	logic [`EBM_LOC_BITS-1:0] s_rd_loc;
	ebm_shape_t s_shape;
	logic s_wr_fall;
	logic s_rd_fall;

	assign {s_wr_clk, s_wr_en, s_wr_gate} = wrc_sync_reg;
	assign {s_wr_loc, s_wr_data, s_wr_mask} = wrd_sync_reg;
	assign {s_rd_clk, s_rd_en, s_rd_gate} = rdc_sync_reg;
	assign s_rd_loc = rdl_sync_reg;
	assign s_shape = ebm_shape_t'(shape_sync_reg);
	assign s_wr_fall = pol_sync_reg[1];
	assign s_rd_fall = pol_sync_reg[0];

	// Low after reset matches the idle port clock: no false edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_clk_prev_reg <= 1'b0;
		end else begin
			wr_clk_prev_reg <= s_wr_clk;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_clk_prev_reg <= 1'b0;
		end else begin
			rd_clk_prev_reg <= s_rd_clk;
		end
	end

	// Active edge of a synchronised port clock
	function automatic logic edge_seen(input logic fall, input logic prev,
			input logic now);
		edge_seen = fall ? (prev & ~now) : (~prev & now);
	endfunction

	// Edge polarity chosen per port
	logic wr_edge;
	logic rd_edge;
	assign wr_edge = edge_seen(s_wr_fall, wr_clk_prev_reg, s_wr_clk);
	assign rd_edge = edge_seen(s_rd_fall, rd_clk_prev_reg, s_rd_clk);

	// Array input registers, write side
	logic wr_pend_reg;
	logic [`EBM_ROW_BITS-1:0] wr_row_reg;
	logic [`EBM_WORD_BITS-1:0] wr_data_reg;
	logic [`EBM_WORD_BITS-1:0] wr_bits_reg;
	logic [`EBM_WORD_BITS-1:0] wr_data_next;
	logic [`EBM_WORD_BITS-1:0] wr_bits_next;

	always_comb begin
		wr_bits_next = lane_bits(s_shape, s_wr_loc);
		if (s_shape == EBM_SHAPE_256X16) begin
			wr_bits_next = wr_bits_next & ~s_wr_mask;
		end
	end

	// Narrow words repeat across the row so any lane sees them
	always_comb begin
		case (s_shape)
			EBM_SHAPE_256X16: wr_data_next = s_wr_data;
			EBM_SHAPE_512X8: wr_data_next = {2{s_wr_data[7:0]}};
			EBM_SHAPE_1024X4: wr_data_next = {4{s_wr_data[3:0]}};
			EBM_SHAPE_2048X2: wr_data_next = {8{s_wr_data[1:0]}};
			default: wr_data_next = s_wr_data;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= wr_edge & s_wr_en & s_wr_gate;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_row_reg <= '0;
			wr_data_reg <= `EBM_WORD_RESET;
			wr_bits_reg <= `EBM_WORD_RESET;
		end else if (wr_edge) begin
			wr_row_reg <= s_wr_loc[`EBM_ROW_BITS-1:0];
			wr_data_reg <= wr_data_next;
			wr_bits_reg <= wr_bits_next;
		end
	end

	// Array input registers, read side
	logic rd_pend_reg;
	logic [`EBM_LOC_BITS-1:0] rd_loc_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= rd_edge & s_rd_en & s_rd_gate;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_loc_reg <= '0;
		end else if (rd_edge) begin
			rd_loc_reg <= s_rd_loc;
		end
	end

	// 256 rows of 16 bits, 4 kbit in all
	logic [`EBM_WORD_BITS-1:0] mem [0:`EBM_ROWS-1];

	// Preload port wins over a user write in the same cycle
	always_ff @(posedge core_clk) begin
		if (init_we) begin
			mem[init_location] <= init_word;
		end else if (wr_pend_reg) begin
			for (int b = 0; b < `EBM_WORD_BITS; b++) begin
				if (wr_bits_reg[b]) begin
					mem[wr_row_reg][b] <= wr_data_reg[b];
				end
			end
		end
	end

	// Read port runs beside the write port; a row written in the same
	// cycle returns its old content, which covers the undefined case
	logic [`EBM_WORD_BITS-1:0] rd_word_reg;
	logic [`EBM_WORD_BITS-1:0] rd_word_next;

	logic [`EBM_WORD_BITS-1:0] rd_row_word;
	logic [`EBM_WORD_BITS-1:0] rd_lane_bits;
	logic [3:0] rd_lane_shift;

	// Lane picked out of the row and moved to the low bits
	always_comb begin
		rd_row_word = mem[rd_loc_reg[`EBM_ROW_BITS-1:0]];
		rd_lane_bits = lane_bits(s_shape, rd_loc_reg);
		rd_lane_shift = lane_shift(s_shape, rd_loc_reg);
		rd_word_next = (rd_row_word & rd_lane_bits) >> rd_lane_shift;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_word_reg <= `EBM_WORD_RESET;
		end else if (rd_pend_reg) begin
			rd_word_reg <= rd_word_next;
		end
	end

	assign rd_word = rd_word_reg;

endmodule

//--- tb/ebm_tile_assertions.sv
`timescale 1ns/1ps
module ebm_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire ebm_pkg::ebm_shape_t shape,
	input wire logic rd_clk,
	input wire logic rd_strobe,
	input wire logic rd_clock_gate,
	input wire logic [15:0] rd_word
);
	import ebm_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_rst; $rose(rst_n) |-> rd_word == 16'h0000; endproperty
	a_rst: assert property (p_rst) else $error("word not clear");
	property p_stb; !rd_strobe [*8] |=> $stable(rd_word); endproperty
	a_stb: assert property (p_stb) else $error("read without strobe");
	property p_gate; !rd_clock_gate [*8] |=> $stable(rd_word); endproperty
	a_gate: assert property (p_gate) else $error("read without gate");
	property p_clk; $stable(rd_clk) [*8] |=> $stable(rd_word); endproperty
	a_clk: assert property (p_clk) else $error("read without edge");
	property p_one; $changed(rd_word) |=> $stable(rd_word); endproperty
	a_one: assert property (p_one) else $error("double update");
	property p_w8; $changed(rd_word) && shape == EBM_SHAPE_512X8 |-> !rd_word[15:8]; endproperty
	a_w8: assert property (p_w8) else $error("wide 512x8 word");
	property p_w4; $changed(rd_word) && shape == EBM_SHAPE_1024X4 |-> !rd_word[15:4]; endproperty
	a_w4: assert property (p_w4) else $error("wide 1024x4 word");
	property p_w2; $changed(rd_word) && shape == EBM_SHAPE_2048X2 |-> !rd_word[15:2]; endproperty
	a_w2: assert property (p_w2) else $error("wide 2048x2 word");
	cover property ($changed(rd_word));
	cover property ($changed(rd_word) && shape == EBM_SHAPE_2048X2);
	cover property ($fell(rd_clk) && rd_strobe);
endmodule
bind ebm_tile ebm_chk i_ebm_chk (.core_clk, .rst_n, .shape, .rd_clk, .rd_strobe,
	.rd_clock_gate, .rd_word);

//--- tb/ebm_fabric.sv
`timescale 1ns/1ps
module ebm_fabric (
	input wire logic core_clk,
	output logic wr_clk,
	output logic wr_strobe,
	output logic wr_clock_gate,
	output logic [10:0] wr_location,
	output logic [15:0] wr_data,
	output logic [15:0] wr_mask,
	output logic rd_clk,
	output logic rd_strobe,
	output logic rd_clock_gate,
	output logic [10:0] rd_location
);
	initial {wr_clk, wr_strobe, wr_clock_gate, wr_location, wr_data, wr_mask} = '0;
	initial {rd_clk, rd_strobe, rd_clock_gate, rd_location} = '0;
	// One access at a time, never a read beside a write
	task automatic go(bit ws, bit [1:0] en, logic [10:0] a, logic [15:0] d, m, int ph);
		if (ws)
			{wr_strobe, wr_clock_gate, wr_location, wr_data, wr_mask} <= {en, a, d, m};
		else
			{rd_strobe, rd_clock_gate, rd_location} <= {en, a};
		repeat (ph) @(posedge core_clk);
		{wr_clk, rd_clk} <= {ws, !ws};
		repeat (ph) @(posedge core_clk);
		{wr_clk, rd_clk} <= 2'h0;
		repeat (ph) @(posedge core_clk);
		// Controls drop, location and data lines toggle; the mask holds
		{wr_strobe, wr_clock_gate, rd_strobe, rd_clock_gate} <= 4'h0;
		{wr_location, wr_data, rd_location} <= ~{wr_location, wr_data, rd_location};
		@(posedge core_clk);
	endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ebm_pkg::*;
	logic core_clk = 1'h0, rst_n = 1'h0, wr_falling = 1'h0, rd_falling = 1'h0, init_we = 1'h0;
	logic [7:0] init_location = 8'h00;
	logic [15:0] init_word = 16'h0000, x = 16'h0000, d, m, wr_data, wr_mask, rd_word;
	logic [15:0] mem [256]; // 4 kbit image
	logic [10:0] wr_location, rd_location, wl, rl, lim;
	logic wr_clk, wr_strobe, wr_clock_gate, rd_clk, rd_strobe, rd_clock_gate;
	ebm_shape_t shape = EBM_SHAPE_256X16;
	int miscompares = 0, n_compared = 0, s, w;
	bit [1:0] we, re;
	initial forever #5 core_clk = ~core_clk;
	ebm_fabric i_ebm_fabric (.core_clk, .wr_clk, .wr_strobe, .wr_clock_gate, .wr_location,
		.wr_data, .wr_mask, .rd_clk, .rd_strobe, .rd_clock_gate, .rd_location);
	ebm_tile i_ebm_tile (.core_clk, .rst_n, .shape, .wr_falling, .rd_falling, .wr_clk,
		.wr_strobe, .wr_clock_gate, .wr_location, .wr_data, .wr_mask, .rd_clk, .rd_strobe,
		.rd_clock_gate, .rd_location, .init_we, .init_location, .init_word, .rd_word);
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error rd_word expected %h seen %h", exp, seen);
		end
	endtask
	task automatic close_out;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hb811));
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		for (int r = 0; r < 256; r++) begin
			mem[r] = 16'($urandom);
			{init_we, init_location, init_word} <= {1'h1, 8'(r), mem[r]};
			@(posedge core_clk);
		end
		init_we <= 1'h0;
		for (int i = 0; i < 80; i++) begin
			s = i < 8 ? 0 : $urandom % 4;
			w = 16 >> s;
			lim = 11'((256 << s) - 1) & 11'h703;
			we = 2'(i < 8 ? 0 : $urandom % 4 ? 3 : $urandom);
			re = 2'($urandom % 4 ? 3 : $urandom);
			{wl, rl} = {11'($urandom) & lim, 11'($urandom) & lim};
			{d, m} = $urandom;
			shape <= ebm_shape_t'(s);
			{wr_falling, rd_falling} <= 2'($urandom);
			@(posedge core_clk);
			i_ebm_fabric.go(1, we, wl, d, m, 3 + i % 5);
			for (int b = 0; b < w; b++)
				if (we == 3 && (s > 0 || !m[b]))
					mem[wl[7:0]][wl[10:8] * w + b] = d[b];
			i_ebm_fabric.go(0, re, rl, d, m, 3 + i % 5);
			repeat (3) @(posedge core_clk);
			if (re == 3)
				x = 16'(mem[rl[7:0]] >> rl[10:8] * w) & 16'((1 << w) - 1);
			chk(rd_word, x);
		end
		close_out();
	end
endmodule
